// >>> hbg_bridge.sv
`timescale 1ns/1ps
module hbg_bridge
  import hbg_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        pwm_in,
  input  wire hbg_pkg::hbg_general_type    gen,
  input  wire hbg_pkg::hbg_bridge_cfg_type cfg,
  output hbg_pkg::hbg_gate_type            gate,
  output hbg_pkg::hbg_phase_type           phase
);
  import hbg_pkg::*;

  typedef struct packed {
    logic [1:0]       sync;
    logic             pwm_q;
    hbg_phase_type    ph;
    logic             rising;
    logic [DUR_W-1:0] cnt;
    logic [CUR_W-1:0] pchg;
    logic [CUR_W-1:0] pdchg;
    hbg_gate_type     gate;
  } hbg_bridge_state_type;

  hbg_bridge_state_type st;
  hbg_bridge_state_type next_st;

  function automatic logic [CUR_W-1:0] clamp_cur(
    input logic [CUR_W-1:0] v,
    input logic [CUR_W-1:0] mx
  );
    logic [CUR_W-1:0] r;
    r = v;
    if (r < CUR_MIN)
      r = CUR_MIN;
    if (r > mx)
      r = mx;
    return r;
  endfunction

  // Saturating one-step increase, never past the configured maximum
  function automatic logic [CUR_W-1:0] inc_cur(
    input logic [CUR_W-1:0] v,
    input logic [CUR_W-1:0] mx
  );
    if (v >= mx)
      return clamp_cur(mx, mx);
    return clamp_cur(CUR_W'(v + CUR_MIN), mx);
  endfunction

  logic             pwm_s;
  logic             fw_act;
  logic             adapt;
  logic             pre_on;
  logic [DUR_W-1:0] dur;
  logic [CUR_W-1:0] pre_cur;
  logic [CUR_W-1:0] keep;

  always_comb
  begin
    next_st = st;
    pwm_s   = st.sync[1];
    fw_act  = cfg.fw_en & cfg.pwm_en & ~gen.cnt_sel;
    adapt   = gen.gc_sel[1];
    pre_on  = gen.gc_sel != 2'h0;
    keep    = gen.keep_sel ? KEEP_HIGH : KEEP_LOW;
    dur     = st.rising ? cfg.pchg_dur : cfg.pdchg_dur;
    pre_cur = st.rising ? st.pchg : st.pdchg;
    next_st.sync  = {st.sync[0], pwm_in};
    next_st.pwm_q = pwm_s;
    if (!adapt)
    begin
      next_st.pchg  = clamp_cur(cfg.pchg_init, cfg.pre_max);
      next_st.pdchg = clamp_cur(cfg.pdchg_init, cfg.pre_max);
    end
    next_st.gate.passive_off = 1'b0;
    unique case (cfg.mode)
      MODE_PASSIVE:
      begin
        next_st.ph   = PH_PASSIVE;
        // Track the pin so a later enable starts from its level
        next_st.rising = pwm_s;
        next_st.gate = '0;
        next_st.gate.passive_off = 1'b1;
      end
      MODE_ACT_OFF:
      begin
        next_st.ph   = PH_ACTOFF;
        next_st.rising = pwm_s;
        next_st.gate = '0;
        next_st.gate.high_cur = keep;
        next_st.gate.low_cur  = keep;
      end
      default:
      begin
        if (!cfg.pwm_en || gen.cnt_sel)
        begin
          next_st.ph   = PH_ACTOFF;
          next_st.rising = pwm_s;
          next_st.gate = '0;
          next_st.gate.high_cur = keep;
          next_st.gate.low_cur  = keep;
        end
        else
        begin
          if (pwm_s != st.pwm_q)
          begin
            // Edge starts a new switching sequence
            next_st.rising = pwm_s;
            next_st.cnt    = '0;
            next_st.ph     = pre_on ? PH_PRE_A : PH_MAIN;
            // Step the current of the sequence that just ended
            if (adapt)
            begin
              if (st.rising)
                next_st.pchg = inc_cur(st.pchg, cfg.pre_max);
              else
                next_st.pdchg = inc_cur(st.pdchg, cfg.pre_max);
            end
          end
          else
          begin
            unique case (st.ph)
              PH_PRE_A, PH_PRE_B:
              begin
                next_st.cnt = DUR_W'(st.cnt + 1'b1);
                if (gen.tmod_en && st.ph == PH_PRE_A &&
                    st.cnt >= (dur >> 1))
                  next_st.ph = PH_PRE_B;
                if (st.cnt + 1'b1 >= dur)
                  next_st.ph = PH_MAIN;
              end
              PH_MAIN:
                next_st.ph = fw_act && !st.rising ? PH_FW : PH_HOLD;
              PH_FW:
                next_st.ph = PH_HOLD;
              PH_HOLD:
                next_st.ph = PH_HOLD;
              default:
                next_st.ph = PH_HOLD;
            endcase
          end
          next_st.gate = '0;
          // Active transistor is the PWM-selected one
          begin
            logic hs;
            logic [CUR_W-1:0] act_cur;
            hs = cfg.mode == MODE_HIGH_PWM;
            act_cur = keep;
            pre_cur = next_st.rising ? next_st.pchg : next_st.pdchg;
            unique case (next_st.ph)
              PH_PRE_A:
                act_cur = pre_cur;
              PH_PRE_B:
                act_cur = clamp_cur(pre_cur >> 1, cfg.pre_max);
              PH_MAIN:
                act_cur = next_st.rising ? cfg.chg : cfg.dchg;
              default:
                act_cur = keep;
            endcase
            if (hs)
            begin
              next_st.gate.high_on  = next_st.rising;
              next_st.gate.high_src = next_st.rising;
              next_st.gate.high_cur = act_cur;
              next_st.gate.low_on   = fw_act & ~next_st.rising;
              next_st.gate.low_src  = fw_act & ~next_st.rising;
              next_st.gate.low_cur  = next_st.ph == PH_FW ? cfg.fw_cur
                                      : (next_st.rising ? CUR_MAX : keep);
            end
            else
            begin
              next_st.gate.low_on   = next_st.rising;
              next_st.gate.low_src  = next_st.rising;
              next_st.gate.low_cur  = act_cur;
              next_st.gate.high_on  = fw_act & ~next_st.rising;
              next_st.gate.high_src = fw_act & ~next_st.rising;
              next_st.gate.high_cur = next_st.ph == PH_FW ? cfg.fw_cur
                                      : (next_st.rising ? CUR_MAX : keep);
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st       <= '0;
      st.ph    <= PH_PASSIVE;
      st.pchg  <= CUR_MIN;
      st.pdchg <= CUR_MIN;
      st.gate.passive_off <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign gate  = st.gate;
  assign phase = st.ph;
endmodule

// >>> hbg_mcu_model.sv
`timescale 1ns/1ps
module hbg_mcu_model
(
  input  wire logic [5:0] level,
  output logic [5:0]      pwm_pin
);
  // Controller pins follow the requested levels with no clock relation
  always_comb
    pwm_pin = level;
endmodule

// >>> hbg_pkg.sv
package hbg_pkg;
  localparam int NUM_BRIDGES = 3;
  localparam int CUR_W       = 6;
  localparam int DUR_W       = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_GENERAL  = 8'h00;
  localparam logic [7:0] OFF_MODE     = 8'h04;
  localparam logic [7:0] OFF_PHASE0   = 8'h08;
  localparam logic [7:0] OFF_PREMAX   = 8'h14;
  localparam logic [7:0] OFF_PREINIT0 = 8'h18;
  localparam logic [7:0] OFF_PRETIME0 = 8'h24;
  localparam logic [7:0] OFF_STATUS0  = 8'h30;

  // General register field positions
  localparam int GEN_CNT_SEL  = 0;
  localparam int GEN_GC_LO    = 1;
  localparam int GEN_TMOD     = 3;
  localparam int GEN_DETECT   = 4;
  localparam int GEN_KEEP     = 5;

  // Mode register: per bridge 4 bits {fw_en, pwm_en, mode[1:0]}
  localparam int MODE_STRIDE  = 4;

  localparam logic [CUR_W-1:0] CUR_MAX     = 6'h3f;
  localparam logic [CUR_W-1:0] CUR_MIN     = 6'h01;
  localparam logic [CUR_W-1:0] KEEP_LOW    = 6'h02;
  localparam logic [CUR_W-1:0] KEEP_HIGH   = 6'h08;
  localparam logic [31:0]      GENERAL_RST = 32'h0000_0000;
  localparam logic [31:0]      MODE_RST    = 32'h0000_0000;

  localparam logic [1:0] MODE_PASSIVE = 2'h0;
  localparam logic [1:0] MODE_LOW_PWM = 2'h1;
  localparam logic [1:0] MODE_HIGH_PWM = 2'h2;
  localparam logic [1:0] MODE_ACT_OFF = 2'h3;

  typedef enum logic [6:0] {
    PH_HOLD   = 7'h01,
    PH_PRE_A  = 7'h02,
    PH_PRE_B  = 7'h04,
    PH_MAIN   = 7'h08,
    PH_PASSIVE = 7'h10,
    PH_ACTOFF = 7'h20,
    PH_FW     = 7'h40
  } hbg_phase_type;

  typedef struct packed {
    logic             cnt_sel;
    logic [1:0]       gc_sel;
    logic             tmod_en;
    logic             detect_en;
    logic             keep_sel;
  } hbg_general_type;

  typedef struct packed {
    logic             fw_en;
    logic             pwm_en;
    logic [1:0]       mode;
    logic [CUR_W-1:0] chg;
    logic [CUR_W-1:0] dchg;
    logic [CUR_W-1:0] fw_cur;
    logic [CUR_W-1:0] pre_max;
    logic [CUR_W-1:0] pchg_init;
    logic [CUR_W-1:0] pdchg_init;
    logic [DUR_W-1:0] pchg_dur;
    logic [DUR_W-1:0] pdchg_dur;
  } hbg_bridge_cfg_type;

  typedef struct packed {
    logic             high_on;
    logic             low_on;
    logic             high_src;
    logic             low_src;
    logic [CUR_W-1:0] high_cur;
    logic [CUR_W-1:0] low_cur;
    logic             passive_off;
  } hbg_gate_type;
endpackage

// >>> hbg_top.sv
`timescale 1ns/1ps
module hbg_top
  import hbg_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic [5:0]                 pwm_pin,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic [31:0]                     wb_dat_o,
  output logic                            wb_ack_o,
  output hbg_pkg::hbg_gate_type [2:0]     gate
);
  import hbg_pkg::*;

  typedef struct packed {
    logic [31:0]      general;
    logic [31:0]      mode;
    logic [2:0][31:0] phase_cur;
    logic [31:0]      premax;
    logic [2:0][31:0] preinit;
    logic [2:0][31:0] pretime;
    logic [31:0]      dat;
    logic             ack;
  } hbg_top_state_type;

  hbg_top_state_type st;
  hbg_top_state_type next_st;
  hbg_general_type   gen;
  hbg_bridge_cfg_type [2:0] cfg;
  hbg_gate_type      [2:0] gate_w;
  hbg_phase_type     [2:0] phase_w;

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] d,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    return r;
  endfunction

  always_comb
  begin
    gen.cnt_sel   = st.general[GEN_CNT_SEL];
    gen.gc_sel    = st.general[GEN_GC_LO +: 2];
    gen.tmod_en   = st.general[GEN_TMOD];
    gen.detect_en = st.general[GEN_DETECT];
    gen.keep_sel  = st.general[GEN_KEEP];
  end

  genvar b;
  generate
    for (b = 0; b < NUM_BRIDGES; b++)
    begin : g_br
      always_comb
      begin
        cfg[b].mode       = st.mode[b*MODE_STRIDE +: 2];
        cfg[b].pwm_en     = st.mode[b*MODE_STRIDE + 2];
        cfg[b].fw_en      = st.mode[b*MODE_STRIDE + 3];
        cfg[b].chg        = st.phase_cur[b][0 +: CUR_W];
        cfg[b].dchg       = st.phase_cur[b][8 +: CUR_W];
        cfg[b].fw_cur     = st.phase_cur[b][16 +: CUR_W];
        cfg[b].pre_max    = st.premax[b*8 +: CUR_W];
        cfg[b].pchg_init  = st.preinit[b][0 +: CUR_W];
        cfg[b].pdchg_init = st.preinit[b][8 +: CUR_W];
        cfg[b].pchg_dur   = st.pretime[b][0 +: DUR_W];
        cfg[b].pdchg_dur  = st.pretime[b][8 +: DUR_W];
      end
      hbg_bridge u_br
      (
        .clk    (clk),
        .nrst   (nrst),
        .pwm_in (pwm_pin[2*b]),
        .gen    (gen),
        .cfg    (cfg[b]),
        .gate   (gate_w[b]),
        .phase  (phase_w[b])
      );
    end
  endgenerate

  always_comb
  begin
    logic req;
    logic [7:0] a;
    req = 1'b0;
    a   = wb_adr_i;
    next_st     = st;
    next_st.ack = 1'b0;
    req = wb_cyc_i & wb_stb_i & ~st.ack;
    if (req)
    begin
      next_st.ack = 1'b1;
      next_st.dat = 32'h0000_0000;
      if (a == OFF_GENERAL)
      begin
        next_st.dat = st.general;
        if (wb_we_i)
          next_st.general = merge(st.general, wb_dat_i, wb_sel_i) & 32'h3f;
      end
      if (a == OFF_MODE)
      begin
        next_st.dat = st.mode;
        if (wb_we_i)
          next_st.mode = merge(st.mode, wb_dat_i, wb_sel_i) & 32'hfff;
      end
      if (a == OFF_PREMAX)
      begin
        next_st.dat = st.premax;
        if (wb_we_i)
          next_st.premax = merge(st.premax, wb_dat_i, wb_sel_i);
      end
      for (int i = 0; i < NUM_BRIDGES; i++)
      begin
        if (a == OFF_PHASE0 + 8'(4*i))
        begin
          next_st.dat = st.phase_cur[i];
          if (wb_we_i)
            next_st.phase_cur[i] = merge(st.phase_cur[i], wb_dat_i, wb_sel_i);
        end
        if (a == OFF_PREINIT0 + 8'(4*i))
        begin
          next_st.dat = st.preinit[i];
          if (wb_we_i)
            next_st.preinit[i] = merge(st.preinit[i], wb_dat_i, wb_sel_i);
        end
        if (a == OFF_PRETIME0 + 8'(4*i))
        begin
          next_st.dat = st.pretime[i];
          if (wb_we_i)
            next_st.pretime[i] = merge(st.pretime[i], wb_dat_i, wb_sel_i);
        end
        if (a == OFF_STATUS0 + 8'(4*i))
          next_st.dat = {25'h0, phase_w[i]};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st         <= '0;
      st.general <= GENERAL_RST;
      st.mode    <= MODE_RST;
    end
    else
      st <= next_st;
  end

  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign gate     = gate_w;
endmodule

// >>> hbg_top_props.sv
`timescale 1ns/1ps
module hbg_top_props
  import hbg_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        nrst,
  input wire logic [5:0]                  pwm_pin,
  input wire logic                        wb_cyc_i,
  input wire logic                        wb_stb_i,
  input wire logic                        wb_we_i,
  input wire logic [7:0]                  wb_adr_i,
  input wire logic [3:0]                  wb_sel_i,
  input wire logic [31:0]                 wb_dat_i,
  input wire logic [31:0]                 wb_dat_o,
  input wire logic                        wb_ack_o,
  input wire hbg_pkg::hbg_gate_type [2:0] gate
);
  import hbg_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  ack_latency_a: assert property (s_req |=> s_ans)
    else $error("ack not a single pulse one cycle after request");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  ack_idle_a: assert property ((!wb_cyc_i) [*2] |-> !wb_ack_o)
    else $error("ack while bus idle");
  dat_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved without an access");
  unmapped_zero_a: assert property
    (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h3c |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  status_hot_a: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i inside {8'h30, 8'h34, 8'h38} |-> $onehot0(wb_dat_o))
    else $error("phase status not one-hot");

  for (genvar i = 0; i < NUM_BRIDGES; i++)
  begin : g_br
    gate_excl_a: assert property (!(gate[i].high_on && gate[i].low_on))
      else $error("both gates of a bridge on");
    passive_off_a: assert property (gate[i].passive_off |->
      !gate[i].high_on && !gate[i].low_on)
      else $error("passive discharge with a gate on");
  end
endmodule

bind hbg_top hbg_top_props u_props (.clk(clk), .nrst(nrst),
  .pwm_pin(pwm_pin), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .gate(gate));

// >>> hbg_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module hbg_top_tb;
  import hbg_pkg::*;
  logic               clk;
  logic               nrst;
  logic [5:0]         level;
  logic [5:0]         pwm_pin;
  logic               wb_cyc;
  logic               wb_stb;
  logic               wb_we;
  logic [7:0]         wb_adr;
  logic [3:0]         wb_sel;
  logic [31:0]        wb_dat;
  logic [31:0]        wb_dat_o;
  logic               wb_ack_o;
  hbg_gate_type [2:0] gate;
  logic [31:0]        q;
  int                 bad_count;
  int                 num_checks;

  hbg_mcu_model mcu (.level(level), .pwm_pin(pwm_pin));
  hbg_top uut (.clk(clk), .nrst(nrst), .pwm_pin(pwm_pin),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gate(gate));

  task automatic final_report;
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= s;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1);
    `CHK("ack latency", 2, n)
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0, 4'hf);
  endtask

  // Waits for the masked gate word, bounded, then compares it
  task automatic expect_gate(input int b, input logic [16:0] m,
                             input logic [16:0] v);
    logic [16:0] g;
    g = '0;
    for (int i = 0; i < 80; i++)
    begin
      @(negedge clk);
      g = gate[b] & m;
      if (g === v)
        break;
    end
    @(posedge clk);
    `CHK("gate", v, g)
  endtask

  function automatic logic [16:0] hv(input logic s, input logic [5:0] c);
    return {2'b0, s, 1'b0, c, 7'h0};
  endfunction

  // Expected {high_on, low_on, passive_off} for one-input control
  function automatic logic [2:0] ref_gate(input logic [3:0] n,
                                          input logic l, input logic cs);
    if (n[1:0] == MODE_PASSIVE)
      return 3'b001;
    if (cs || !n[2] || n[1:0] == MODE_ACT_OFF)
      return 3'b000;
    if (n[1:0] == MODE_LOW_PWM)
      return {1'b0, l, 1'b0};
    return {l, !l && n[3], 1'b0};
  endfunction

  task automatic t_regs;
    rd(OFF_GENERAL);
    `CHK("general", GENERAL_RST, q)
    rd(OFF_MODE);
    `CHK("mode", MODE_RST, q)
    wr(OFF_GENERAL, 32'h0000_0015);
    wb(1'b1, OFF_GENERAL, 32'h0, 4'h2);
    rd(OFF_GENERAL);
    `CHK("general", 32'h0000_0015, q)
    wr(8'h3c, 32'hffff_ffff);
    rd(8'h3c);
    `CHK("unmapped", 32'h0, q)
    rd(OFF_STATUS0);
    `CHK("status", 32'(PH_PASSIVE), q)
    for (int b = 0; b < 3; b++)
    begin
      wr(OFF_PHASE0 + 8'(4 * b), 32'h000b_2a15);
      wr(OFF_PREINIT0 + 8'(4 * b), 32'h0000_0430);
      wr(OFF_PRETIME0 + 8'(4 * b), 32'h0000_0303);
    end
    wr(OFF_PREMAX, 32'h000c_0c0c);
  endtask

  task automatic t_modes;
    logic [3:0] nibs [6] = '{4'h0, 4'h5, 4'he, 4'hf, 4'h6, 4'h2};
    logic [2:0] r;
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 6; k++)
        for (int l = 0; l < 2; l++)
        begin
          wr(OFF_GENERAL, 32'(c));
          wr(OFF_MODE, 32'({3{nibs[k]}}));
          level <= {~l[0], l[0], l[0], ~l[0], ~l[0], l[0]};
          for (int b = 0; b < 3; b++)
          begin
            r = ref_gate(nibs[k], l[0] ^ (b == 1), c[0]);
            expect_gate(b, 17'h18001, {r[2:1], 14'h0, r[0]});
          end
        end
  endtask

  task automatic t_currents;
    wr(OFF_GENERAL, 32'h0);
    wr(OFF_MODE, 32'h0000_0eee);
    level <= 6'h00;
    expect_gate(0, 17'h18001, 17'h08000);
    level <= 6'h15;
    expect_gate(0, 17'h05f80, hv(1'b1, 6'h15));
    expect_gate(0, 17'h05f80, hv(1'b1, KEEP_LOW));
    expect_gate(0, 17'h0007e, {10'h0, CUR_MAX, 1'b0});
    level <= 6'h00;
    expect_gate(0, 17'h05f80, hv(1'b0, 6'h2a));
    expect_gate(0, 17'h0207e, {3'b0, 1'b1, 6'h0, 6'h0b, 1'b0});
    // Keep high, adaptive control, time modulation
    wr(OFF_GENERAL, 32'h0000_002c);
    level <= 6'h15;
    expect_gate(0, 17'h05f80, hv(1'b1, 6'h0c));
    expect_gate(0, 17'h05f80, hv(1'b1, 6'h06));
    expect_gate(0, 17'h05f80, hv(1'b1, KEEP_HIGH));
    // Falling edge: pre-discharge one step above its initial code
    level <= 6'h00;
    expect_gate(0, 17'h05f80, hv(1'b0, 6'h05));
    expect_gate(0, 17'h05f80, hv(1'b0, 6'h02));
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    #100000;
    bad_count++;
    final_report();
  end

  initial
  begin
    nrst = 1'b0;
    level = 6'h00;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat = 32'h0;
    bad_count = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_modes();
    t_currents();
    final_report();
  end
endmodule
